// [core/usb_irq_pkg.sv]
package usb_irq_pkg;

	// register byte offsets (word aligned, plain port)
	localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h10;
	localparam logic [7:0] OFS_IRQ_DISABLE = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h1c;
	localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h20;
	localparam logic [7:0] OFS_EP_RESET    = 8'h28;

	// field positions
	localparam int unsigned NUM_EP          = 6;
	localparam int unsigned BIT_SUSPEND     = 8;
	localparam int unsigned BIT_RESUME      = 9;
	localparam int unsigned BIT_EXT_RESUME  = 10;
	localparam int unsigned BIT_FRAME_START = 11;
	localparam int unsigned BIT_BUS_RESET   = 12;
	localparam int unsigned BIT_WAKEUP      = 13;

	// writable global mask bits (suspend, resume, ext resume, sof, wakeup)
	localparam logic [31:0] GLOBAL_MASK_BITS  = 32'h0000_2f00;
	// status bits clearable by the clear register
	localparam logic [31:0] CLEARABLE_BITS    = 32'h0000_3f00;
	localparam logic [31:0] EP_BITS           = 32'h0000_003f;
	localparam logic [31:0] UNMASKABLE_BIT    = 32'h0000_1000;

	// values after reset: resume mask enabled
	localparam logic [31:0] MASK_RESET_VALUE   = 32'h0000_0200;
	localparam logic [31:0] STATUS_RESET_VALUE = 32'h0000_0000;
	localparam logic [5:0]  EP_RESET_VALUE     = 6'h00;

	// idle time before suspend
	localparam int unsigned SUSPEND_IDLE_US = 3000;
	localparam int unsigned CLK_MHZ         = 250;
	localparam int unsigned SUSPEND_CYCLES  = SUSPEND_IDLE_US * CLK_MHZ;

endpackage

// [core/usb_irq_ep_reset.sv]
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - mask bits for suspend, resume, ext resume, sof, wakeup read enabled state
// - mask view bit 12 always reads one
// - resume mask comes up enabled after reset
// - six endpoint status bits show pending endpoint interrupts
// - endpoint interrupt raised when any of its five flags is set
// - endpoint status follows its flags, not cleared by clear register
// - set suspend status and enter suspend after 3ms bus idle
// - set resume status on resume signalling at the port
// - set frame start status on every sof token
// - set bus reset end status at end of bus reset; ready for endpoint 0
// - wakeup status set on host resume or reset since last clear
// - external resume status shows a raised external resume
// - writing one to clear register clears status bit; zero no effect
// - endpoint reset bit holds that endpoint fifo pointers at zero
// - endpoint reset returns data toggle to data0, flags untouched
// - enable write sets mask bits, disable write clears them
module usb_irq_ep_reset
	import usb_irq_pkg::*;
#(
	parameter int unsigned SUSPEND_IDLE_CYCLES = SUSPEND_CYCLES
)(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// register port
	input  wire logic [7:0]       addr_i,
	input  wire logic [31:0]      wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output logic      [31:0]      rdata_o,
	// events from the transaction engine (same clock)
	input  wire logic             bus_activity_i,
	input  wire logic             resume_det_i,
	input  wire logic             ext_resume_i,
	input  wire logic             sof_det_i,
	input  wire logic             bus_reset_end_i,
	// per-endpoint flags from the control/status registers
	input  wire logic [NUM_EP-1:0] setup_received_i,
	input  wire logic [NUM_EP-1:0] rx_bank_a_full_i,
	input  wire logic [NUM_EP-1:0] rx_bank_b_full_i,
	input  wire logic [NUM_EP-1:0] tx_complete_i,
	input  wire logic [NUM_EP-1:0] stall_acknowledged_i,
	// endpoint reset controls toward fifos and toggles
	output logic      [NUM_EP-1:0] fifo_ptr_clear_o,
	output logic      [NUM_EP-1:0] toggle_to_data0_o,
	// state and interrupt
	output logic                  suspended_o,
	output logic                  ep0_ready_o,
	output logic                  irq_o
);

	// idle counter needs at least two cycles to tell idle from activity
	if (SUSPEND_IDLE_CYCLES < 2)
	begin : g_bad_idle
		$error("SUSPEND_IDLE_CYCLES too small");
	end

	logic [31:0] mask_ff;
	logic [31:0] status_ff;
	logic [5:0]  ep_reset_ff;
	logic [31:0] idle_cnt_ff;
	logic        suspended_ff;
	logic        ep0_ready_ff;
	logic [31:0] rdata_ff;
	logic [31:0] ep_pending;
	logic [31:0] mask_view;
	logic [31:0] status_view;
	logic [31:0] set_events;
	logic        suspend_hit;
	logic        wr_en;
	logic        wr_dis;
	logic        wr_clr;
	logic        wr_rst;

	// write decode
	assign wr_en  = wr_i && (addr_i == OFS_IRQ_ENABLE);
	assign wr_dis = wr_i && (addr_i == OFS_IRQ_DISABLE);
	assign wr_clr = wr_i && (addr_i == OFS_IRQ_CLEAR);
	assign wr_rst = wr_i && (addr_i == OFS_EP_RESET);

	// endpoint status is live from the flags, so it stays until they clear
	genvar ep;
	generate
		for (ep = 0; ep < NUM_EP; ep++)
		begin : g_ep
			assign ep_pending[ep] = setup_received_i[ep] | rx_bank_a_full_i[ep]
				| rx_bank_b_full_i[ep] | tx_complete_i[ep]
				| stall_acknowledged_i[ep];
		end
	endgenerate
	assign ep_pending[31:NUM_EP] = '0;

	// idle counter for suspend detection
	assign suspend_hit = !suspended_ff && !bus_activity_i
		&& (idle_cnt_ff == SUSPEND_IDLE_CYCLES - 1);

	always_ff @(posedge clk_i)
	begin
		if (rst_i || bus_activity_i)
			idle_cnt_ff <= '0;
		else if (!suspended_ff)
			idle_cnt_ff <= idle_cnt_ff + 32'h0000_0001;
	end

	// suspend mode: left on any bus activity
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			suspended_ff <= 1'b0;
		else if (bus_activity_i)
			suspended_ff <= 1'b0;
		else if (suspend_hit)
			suspended_ff <= 1'b1;
	end

	// endpoint 0 ready once a bus reset has ended
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ep0_ready_ff <= 1'b0;
		else if (bus_reset_end_i)
			ep0_ready_ff <= 1'b1;
	end

	// mask: enable sets, disable clears; enable wins if both in one write
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mask_ff <= MASK_RESET_VALUE;
		else if (wr_en)
			mask_ff <= mask_ff | (wdata_i & (GLOBAL_MASK_BITS | EP_BITS));
		else if (wr_dis)
			mask_ff <= mask_ff & ~(wdata_i & (GLOBAL_MASK_BITS | EP_BITS));
	end

	// sticky global event flags
	always_comb
	begin
		set_events = '0;
		set_events[BIT_SUSPEND]     = suspend_hit;
		set_events[BIT_RESUME]      = resume_det_i;
		set_events[BIT_EXT_RESUME]  = ext_resume_i;
		set_events[BIT_FRAME_START] = sof_det_i;
		set_events[BIT_BUS_RESET]   = bus_reset_end_i;
		set_events[BIT_WAKEUP]      = resume_det_i | bus_reset_end_i;
	end

	// a set arriving in the clearing cycle wins over the clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_ff <= STATUS_RESET_VALUE;
		else if (wr_clr)
			status_ff <= (status_ff & ~(wdata_i & CLEARABLE_BITS)) | set_events;
		else
			status_ff <= status_ff | set_events;
	end

	// endpoint reset register drives fifo pointer and toggle clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ep_reset_ff <= EP_RESET_VALUE;
		else if (wr_rst)
			ep_reset_ff <= wdata_i[NUM_EP-1:0];
	end

	assign fifo_ptr_clear_o  = ep_reset_ff;
	assign toggle_to_data0_o = ep_reset_ff;

	// register views
	assign mask_view   = (mask_ff & (GLOBAL_MASK_BITS | EP_BITS)) | UNMASKABLE_BIT;
	assign status_view = (status_ff & CLEARABLE_BITS) | ep_pending;

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !rd_i)
			rdata_ff <= '0;
		else
		begin
			unique case (addr_i)
				OFS_IRQ_MASK:   rdata_ff <= mask_view;
				OFS_IRQ_STATUS: rdata_ff <= status_view;
				OFS_EP_RESET:   rdata_ff <= {26'h0, ep_reset_ff};
				default:        rdata_ff <= '0; // write-only or unmapped
			endcase
		end
	end

	assign rdata_o     = rdata_ff;
	assign suspended_o = suspended_ff;
	assign ep0_ready_o = ep0_ready_ff;
	assign irq_o       = |(status_view & mask_view);

endmodule

`default_nettype wire

// [tb/usb_irq_ep_reset_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module usb_irq_checker
	import usb_irq_pkg::*;
(
	// clock, reset, register port
	input wire logic clk_i, rst_i, wr_i, rd_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i, rdata_o,
	// events and flags
	input wire logic resume_det_i, ext_resume_i, bus_reset_end_i,
	input wire logic [NUM_EP-1:0] setup_received_i, rx_bank_a_full_i, rx_bank_b_full_i,
	input wire logic [NUM_EP-1:0] tx_complete_i, stall_acknowledged_i,
	// outputs
	input wire logic [NUM_EP-1:0] fifo_ptr_clear_o, toggle_to_data0_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// one-cycle register read of a given place
	sequence s_rd(logic [7:0] a);
		rd_i && addr_i == a;
	endsequence
	a_mask_unmaskable_mask_bit: assert property (s_rd(OFS_IRQ_MASK) |=> rdata_o[12])
		else $error("mask bit 12 reads low");
	a_status_ep_or: assert property (s_rd(OFS_IRQ_STATUS) |=> rdata_o[5:0] ==
		$past(setup_received_i | rx_bank_a_full_i | rx_bank_b_full_i | tx_complete_i
		| stall_acknowledged_i)) else $error("endpoint status wrong");
	a_ext_sets: assert property (ext_resume_i ##1 s_rd(OFS_IRQ_STATUS) |=> rdata_o[10])
		else $error("ext resume not set");
	a_resume_wakes: assert property (resume_det_i ##1 s_rd(OFS_IRQ_STATUS)
		|=> rdata_o[9] && rdata_o[13]) else $error("resume or wakeup not set");
	a_clear_ext: assert property ((wr_i && addr_i == OFS_IRQ_CLEAR && wdata_i[10]
		&& !ext_resume_i) ##1 !ext_resume_i ##1 s_rd(OFS_IRQ_STATUS) ##0 !ext_resume_i
		|=> !rdata_o[10])
		else $error("clear failed");
	a_bus_reset_irq: assert property (bus_reset_end_i |=> irq_o)
		else $error("bus reset end missed irq");
	a_ep_follow: assert property ($past(wr_i) && $past(addr_i) == OFS_EP_RESET
		&& !$past(rst_i) |-> fifo_ptr_clear_o == $past(wdata_i[5:0]))
		else $error("ep reset not written");
	a_ep_hold: assert property (!$past(wr_i) && !$past(rst_i) |-> $stable(fifo_ptr_clear_o))
		else $error("ep reset moved");
	a_toggle_tied: assert property (toggle_to_data0_o == fifo_ptr_clear_o)
		else $error("toggle reset differs");
endmodule
bind usb_irq_ep_reset usb_irq_checker chk_inst (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i),
	.rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
	.resume_det_i(resume_det_i), .ext_resume_i(ext_resume_i),
	.bus_reset_end_i(bus_reset_end_i), .setup_received_i(setup_received_i),
	.rx_bank_a_full_i(rx_bank_a_full_i), .rx_bank_b_full_i(rx_bank_b_full_i),
	.tx_complete_i(tx_complete_i), .stall_acknowledged_i(stall_acknowledged_i),
	.fifo_ptr_clear_o(fifo_ptr_clear_o), .toggle_to_data0_o(toggle_to_data0_o), .irq_o(irq_o));
`default_nettype wire

// [tb/usb_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module usb_host_model (
	// clock
	input wire logic clk_i,
	// bus events
	output logic act_o, res_o, ext_o, sof_o, bre_o,
	// endpoint flags
	output logic [5:0] f0_o, f1_o, f2_o, f3_o, f4_o
);
	logic [3:0] ev = 4'h0;
	logic [5:0] fl [5] = '{default: 6'h00};
	initial act_o = 1'b1;
	// bus goes quiet from the next edge on
	task idle;
		@(posedge clk_i) act_o <= 1'b0;
	endtask
	assign {bre_o, sof_o, ext_o, res_o} = ev;
	assign {f0_o, f1_o, f2_o, f3_o, f4_o} = {fl[0], fl[1], fl[2], fl[3], fl[4]};
	// events last one cycle, so the caller may read right after
	always @(posedge clk_i)
		if (ev != 4'h0)
			ev <= 4'h0;
	task pulse(input int k);
		@(posedge clk_i) ev <= 4'h1 << k;
	endtask
	task flag(input int k, input logic [5:0] v);
		@(posedge clk_i) fl[k] <= v;
	endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
	$display("wrong value at %0t: %h expected %h", $time, a, b); end end
module testbench
	import usb_irq_pkg::*;
;
	logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0, rdata_o;
	logic act, res, ext, sof, bre, susp, rdy, irq_o;
	logic [5:0] f0, f1, f2, f3, f4, clr, tog;
	int err_count = 0, compares = 0, k;
	logic [31:0] exp_ev [4] = '{32'h2200, 32'h0400, 32'h0800, 32'h3000};
	always #2 clk_i = ~clk_i;
	usb_host_model host_inst (.clk_i(clk_i), .act_o(act), .res_o(res), .ext_o(ext),
		.sof_o(sof), .bre_o(bre), .f0_o(f0), .f1_o(f1), .f2_o(f2), .f3_o(f3), .f4_o(f4));
	usb_irq_ep_reset #(.SUSPEND_IDLE_CYCLES(20)) usb_irq_ep_reset_inst (.clk_i(clk_i),
		.rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .bus_activity_i(act), .resume_det_i(res), .ext_resume_i(ext),
		.sof_det_i(sof), .bus_reset_end_i(bre), .setup_received_i(f0),
		.rx_bank_a_full_i(f1), .rx_bank_b_full_i(f2), .tx_complete_i(f3),
		.stall_acknowledged_i(f4), .fifo_ptr_clear_o(clr), .toggle_to_data0_o(tog),
		.suspended_o(susp), .ep0_ready_o(rdy), .irq_o(irq_o));
	// one-cycle write, outputs settle before return
	task bw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
		@(posedge clk_i) wr_i <= 1'b0;
		#1;
	endtask
	// read data stands only in the cycle after the strobe
	task br(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i) {rd_i, addr_i} <= {1'b1, a};
		@(posedge clk_i) rd_i <= 1'b0;
		#1 `CHK(rdata_o, e)
	endtask
	task end_of_test;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		bw(OFS_IRQ_CLEAR, CLEARABLE_BITS);
		br(OFS_IRQ_MASK, 32'h1200);
		bw(OFS_IRQ_ENABLE, 32'h2f3f);
		bw(OFS_IRQ_DISABLE, 32'h0800);
		bw(OFS_IRQ_ENABLE, 32'h0);
		br(OFS_IRQ_MASK, 32'h373f);
		br(8'h3c, 32'h0);
		for (k = 0; k < 4; k++)
		begin
			host_inst.pulse(k);
			br(OFS_IRQ_STATUS, exp_ev[k]);
			`CHK(irq_o, k != 2)
			bw(OFS_IRQ_CLEAR, ~exp_ev[k]);
			br(OFS_IRQ_STATUS, exp_ev[k]);
			bw(OFS_IRQ_CLEAR, exp_ev[k]);
			br(OFS_IRQ_STATUS, 32'h0);
			`CHK(irq_o, 1'b0)
		end
		`CHK(rdy, 1'b1)
		for (k = 0; k < 5; k++)
		begin
			host_inst.flag(k, 6'h21 << k);
			bw(OFS_IRQ_CLEAR, 32'h3f3f);
			br(OFS_IRQ_STATUS, {26'h0, 6'(6'h21 << k)});
			`CHK(irq_o, 1'b1)
			host_inst.flag(k, 6'h00);
		end
		host_inst.flag(0, 6'h01);
		bw(OFS_EP_RESET, 32'h21);
		`CHK(clr, 6'h21)
		`CHK(tog, 6'h21)
		br(OFS_EP_RESET, 32'h21);
		br(OFS_IRQ_STATUS, 32'h1);
		bw(OFS_EP_RESET, 32'h0);
		`CHK(clr, 6'h00)
		host_inst.flag(0, 6'h00);
		host_inst.idle;
		repeat (25) @(posedge clk_i);
		#1 `CHK(susp, 1'b1)
		br(OFS_IRQ_STATUS, 32'h100);
		end_of_test;
	end
	// run needs well under 1000 cycles
	initial
	begin
		#20000 err_count++;
		end_of_test;
	end
endmodule
`default_nettype wire
